// ==== hw/eic_pkg.sv ====
// Package: register map, fields and encodings of the external interrupt controller
package eic_pkg;
   localparam logic [11:0] ADDR_PRIO_A   = 12'h000;
   localparam logic [11:0] ADDR_PRIO_B   = 12'h004;
   localparam logic [11:0] ADDR_PRIO_H   = 12'h008;
   localparam logic [11:0] ADDR_CONTROL  = 12'h00c;
   localparam logic [11:0] ADDR_STATUS   = 12'h010;
   localparam logic [11:0] ADDR_CPU_MASK = 12'h014;
   localparam logic [11:0] ADDR_ACCEPT   = 12'h018;
   localparam logic [11:0] ADDR_ACK      = 12'h01c;
   localparam int NMI_LEVEL_BIT  = 15;
   localparam int NMI_EDGE_BIT   = 8;
   localparam logic [15:0] PRIO_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   // Writable positions: bits 7..4 and 1..0
   localparam logic [15:0] REQ_FIELD_MASK = 16'h00f3;
   localparam int NUM_PINS = 6;
   localparam logic [3:0] NMI_LEVEL = 4'hf;
   localparam logic [4:0] NMI_SOURCE = 5'h10;
   localparam logic [4:0] NO_SOURCE  = 5'h1f;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD    = 3'b010;
endpackage

// ==== hw/eic_pin_detect.sv ====
// One synchronised external pin with level or edge detection
module eic_pin_detect (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin,
   output logic      sample,
   output logic      fall,
   output logic      rise
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } eic_sync_type;
   eic_sync_type st_reg;
   eic_sync_type st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.meta = pin;
      st_next.sync = st_reg.meta;
      st_next.prev = st_reg.sync;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   // Only synchronised samples are compared
   assign sample = st_reg.sync;
   assign fall   = st_reg.prev & ~st_reg.sync;
   assign rise   = ~st_reg.prev & st_reg.sync;
endmodule

// ==== hw/eic_ctrl.sv ====
// External interrupt controller: pin detection, request flags, arbitration and AHB registers
//
// Added by the designer: the address map and the AHB-Lite slave port.
module eic_ctrl
   import eic_pkg::*;
#(
   parameter int NPINS = eic_pkg::NUM_PINS
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        nmi_pin,
   input  wire logic [NPINS-1:0] ext_req_n,
   input  wire logic [3:0]  cpu_mask_level,
   input  wire logic        cpu_accept,
   output logic             cpu_irq,
   output logic      [3:0]  irq_level,
   output logic      [4:0]  irq_source
);
   import eic_pkg::*;

   typedef struct packed {
      logic [15:0] prio_a;
      logic [15:0] prio_b;
      logic [15:0] prio_h;
      logic        nmi_edge_select;
      logic [NPINS-1:0] sense;
      logic [NPINS-1:0] edge_flag;
      logic [NPINS-1:0] read_one;
      logic        nmi_pending;
      logic        dp_valid;
      logic        dp_write;
      logic [11:0] dp_addr;
      logic [31:0] rdata;
      logic        irq;
      logic [3:0]  level;
      logic [4:0]  source;
   } eic_state_type;

   eic_state_type st_reg;
   eic_state_type st_next;

   logic [NPINS-1:0] pin_low;
   logic [NPINS-1:0] pin_fall;
   logic             nmi_sample;
   logic             nmi_fall;
   logic             nmi_rise;

   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         logic smp;
         eic_pin_detect u_det (
            .clock  (clock),
            .rst    (rst),
            .pin    (ext_req_n[g]),
            .sample (smp),
            .fall   (pin_fall[g]),
            .rise   ()
         );
         assign pin_low[g] = ~smp;
      end
   endgenerate

   eic_pin_detect u_nmi (
      .clock  (clock),
      .rst    (rst),
      .pin    (nmi_pin),
      .sample (nmi_sample),
      .fall   (nmi_fall),
      .rise   (nmi_rise)
   );

   // Pin index 0..5 maps to bits 7,6,5,4,1,0 of the flag and sense fields
   function automatic logic [15:0] spread(input logic [NPINS-1:0] v);
      spread = {8'h00, v[0], v[1], v[2], v[3], 2'b00, v[4], v[5]};
   endfunction

   function automatic logic [NPINS-1:0] gather(input logic [15:0] w);
      gather = {w[0], w[1], w[4], w[5], w[6], w[7]};
   endfunction

   // Priority field of each pin: a[15:12],a[11:8],a[7:4],a[3:0],b[7:4],b[3:0]
   function automatic logic [3:0] pin_prio(input logic [15:0] a, input logic [15:0] b,
                                           input int unsigned i);
      case (i)
         0:       pin_prio = a[15:12];
         1:       pin_prio = a[11:8];
         2:       pin_prio = a[7:4];
         3:       pin_prio = a[3:0];
         4:       pin_prio = b[7:4];
         default: pin_prio = b[3:0];
      endcase
   endfunction

   logic [NPINS-1:0] flags;
   logic [15:0]      control_word;
   logic [15:0]      status_word;
   logic [3:0]       best_level;
   logic [4:0]       best_source;
   logic             best_valid;
   logic             addr_phase;

   assign flags = (pin_low & ~st_reg.sense) | (st_reg.edge_flag & st_reg.sense);
   // Sense bits sit in the low byte only, so the two halves can be or-ed
   assign control_word = {nmi_sample, 6'b000000, st_reg.nmi_edge_select, 8'h00}
                         | spread(st_reg.sense);
   assign status_word  = spread(flags);

   always_comb begin
      best_valid  = st_reg.nmi_pending;
      best_level  = NMI_LEVEL;
      best_source = st_reg.nmi_pending ? NMI_SOURCE : NO_SOURCE;
      if (!st_reg.nmi_pending) begin
         // Ascending scan with >= would favour later pins; strict > keeps lower index
         for (int unsigned i = 0; i < NPINS; i++) begin
            if (flags[i] && (!best_valid ||
                pin_prio(st_reg.prio_a, st_reg.prio_b, i) > best_level)) begin
               best_valid  = 1'b1;
               best_level  = pin_prio(st_reg.prio_a, st_reg.prio_b, i);
               best_source = 5'(i);
            end
         end
      end
   end

   assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);

   always_comb begin
      logic [NPINS-1:0] wr_clear;
      logic [15:0]      wd;
      wr_clear = '0;
      wd       = hwdata[15:0];
      st_next  = st_reg;

      st_next.dp_valid = addr_phase;
      st_next.dp_write = hwrite;
      st_next.dp_addr  = haddr[11:0];
      st_next.rdata    = 32'h0000_0000;

      if (addr_phase && !hwrite) begin
         if (haddr[11:0] == ADDR_PRIO_A) begin
            st_next.rdata = {16'h0000, st_reg.prio_a};
         end else if (haddr[11:0] == ADDR_PRIO_B) begin
            st_next.rdata = {16'h0000, st_reg.prio_b};
         end else if (haddr[11:0] == ADDR_PRIO_H) begin
            st_next.rdata = {16'h0000, st_reg.prio_h};
         end else if (haddr[11:0] == ADDR_CONTROL) begin
            st_next.rdata = {16'h0000, control_word};
         end else if (haddr[11:0] == ADDR_STATUS) begin
            st_next.rdata = {16'h0000, status_word};
            st_next.read_one = st_reg.read_one | flags;
         end else if (haddr[11:0] == ADDR_CPU_MASK) begin
            st_next.rdata = {28'h0000000, cpu_mask_level};
         end else if (haddr[11:0] == ADDR_ACCEPT) begin
            st_next.rdata = {22'h000000, st_reg.irq, st_reg.level, st_reg.source};
         end
      end

      if (st_reg.dp_valid && st_reg.dp_write) begin
         if (st_reg.dp_addr == ADDR_PRIO_A) begin
            st_next.prio_a = wd;
         end else if (st_reg.dp_addr == ADDR_PRIO_B) begin
            st_next.prio_b = {8'h00, wd[7:0]};
         end else if (st_reg.dp_addr == ADDR_PRIO_H) begin
            st_next.prio_h = {wd[15:12], 12'h000};
         end else if (st_reg.dp_addr == ADDR_CONTROL) begin
            st_next.nmi_edge_select = wd[NMI_EDGE_BIT];
            st_next.sense           = gather(wd & REQ_FIELD_MASK);
         end else if (st_reg.dp_addr == ADDR_STATUS) begin
            wr_clear = ~gather(wd) & st_reg.read_one & st_reg.sense;
            // Keep a read-as-one taken by a read in the same cycle
            st_next.read_one = st_next.read_one & ~wr_clear;
         end
      end

      // Exception accepted for a pin: drop its latched request
      if (cpu_accept && st_reg.irq && st_reg.source < NMI_SOURCE) begin
         wr_clear[st_reg.source[2:0]] = 1'b1;
      end
      if (cpu_accept && st_reg.irq && st_reg.source == NMI_SOURCE) begin
         st_next.nmi_pending = 1'b0;
      end

      // Set wins over clear; flags hold until cleared
      // Falls in level mode are not latched, so a switch to edge mode starts clean unless a flag is left from earlier edge mode
      st_next.edge_flag = (st_reg.edge_flag & ~wr_clear)
                        | (pin_fall & st_reg.sense);
      st_next.read_one  = st_next.read_one & st_next.edge_flag;
      if (st_reg.nmi_edge_select ? nmi_rise : nmi_fall) begin
         st_next.nmi_pending = 1'b1;
      end

      st_next.irq    = best_valid && (best_level > cpu_mask_level) && !cpu_accept;
      st_next.level  = best_level;
      st_next.source = best_source;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.prio_a <= PRIO_RESET;
         st_reg.prio_b <= PRIO_RESET;
         st_reg.prio_h <= PRIO_RESET;
         st_reg.source <= NO_SOURCE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = st_reg.rdata;
   assign cpu_irq    = st_reg.irq;
   assign irq_level  = st_reg.level;
   assign irq_source = st_reg.source;

   chk_level_follow_pin: assert property (@(posedge clock) disable iff (rst)
      !st_reg.sense[0] |-> (status_word[7] == pin_low[0]))
      else $error("level flag does not follow pin");

   chk_edge_latch: assert property (@(posedge clock) disable iff (rst)
      (st_reg.sense[0] && pin_fall[0]) |=> st_reg.edge_flag[0])
      else $error("falling edge not latched");

   chk_edge_hold: assert property (@(posedge clock) disable iff (rst)
      (st_reg.edge_flag[1] && !cpu_accept && !(st_reg.dp_valid && st_reg.dp_write))
      |=> st_reg.edge_flag[1])
      else $error("pending edge request lost");

   chk_mask_compare: assert property (@(posedge clock) disable iff (rst)
      st_reg.irq |-> $past(best_level) > $past(cpu_mask_level))
      else $error("request at or below mask forwarded");

   chk_forward_above: assert property (@(posedge clock) disable iff (rst)
      (best_valid && best_level > cpu_mask_level && !cpu_accept) |=> st_reg.irq)
      else $error("request above mask not forwarded");

   chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      (status_word[15:8] == 8'h00) && (control_word[14:9] == 6'h00)
      && (status_word[3:2] == 2'b00) && (control_word[3:2] == 2'b00))
      else $error("reserved bits not zero");

   chk_nmi_level: assert property (@(posedge clock) disable iff (rst)
      control_word[NMI_LEVEL_BIT] == nmi_sample)
      else $error("nmi level bit wrong");

   chk_nmi_edge: assert property (@(posedge clock) disable iff (rst)
      (!st_reg.nmi_edge_select && nmi_fall) |=> st_reg.nmi_pending)
      else $error("nmi falling edge missed");

   chk_auto_clear: assert property (@(posedge clock) disable iff (rst)
      (cpu_accept && st_reg.irq && st_reg.source == 5'h00 && !pin_fall[0])
      |=> !st_reg.edge_flag[0])
      else $error("accepted request not cleared");

   chk_highest_wins: assert property (@(posedge clock) disable iff (rst)
      (flags[0] && flags[1] && !st_reg.nmi_pending && st_reg.prio_a[11:8] > st_reg.prio_a[15:12])
      |-> best_source != 5'h00)
      else $error("lower priority selected");

   chk_nmi_rise_edge: assert property (@(posedge clock) disable iff (rst)
      (st_reg.nmi_edge_select && nmi_rise) |=> st_reg.nmi_pending)
      else $error("nmi rising edge missed");

   chk_nmi_edge_ignored: assert property (@(posedge clock) disable iff (rst)
      (!st_reg.nmi_edge_select && nmi_rise && !st_reg.nmi_pending) |=> !st_reg.nmi_pending)
      else $error("nmi wrong edge taken");

   chk_level_no_latch: assert property (@(posedge clock) disable iff (rst)
      (!st_reg.sense[0] && !st_reg.edge_flag[0]) |=> !st_reg.edge_flag[0])
      else $error("level mode latched an edge");

   chk_sw_clear: assert property (@(posedge clock) disable iff (rst)
      (st_reg.dp_valid && st_reg.dp_write && st_reg.dp_addr == ADDR_STATUS && !hwdata[6]
       && st_reg.read_one[1] && st_reg.sense[1] && !pin_fall[1]) |=> !st_reg.edge_flag[1])
      else $error("flag not cleared after read");

   chk_unread_kept: assert property (@(posedge clock) disable iff (rst)
      (st_reg.edge_flag[1] && !st_reg.read_one[1] && !cpu_accept) |=> st_reg.edge_flag[1])
      else $error("unread flag cleared");

   chk_reset_pending: assert property (@(posedge clock)
      rst |=> (st_reg.edge_flag == '0 && !st_reg.nmi_pending && !st_reg.irq))
      else $error("pending request survived reset");

   chk_reset_config: assert property (@(posedge clock)
      rst |=> (st_reg.sense == '0 && !st_reg.nmi_edge_select && st_reg.prio_a == PRIO_RESET))
      else $error("configuration not reset");

   chk_mask_blocks: assert property (@(posedge clock) disable iff (rst)
      (best_valid && best_level <= cpu_mask_level) |=> !st_reg.irq)
      else $error("masked request forwarded");

   chk_level_presented: assert property (@(posedge clock) disable iff (rst)
      st_reg.irq |-> (st_reg.level == $past(best_level)))
      else $error("presented level wrong");

   chk_nmi_selected: assert property (@(posedge clock) disable iff (rst)
      st_reg.nmi_pending |-> (best_source == NMI_SOURCE && best_level == NMI_LEVEL))
      else $error("nmi not selected first");

   chk_tie_order: assert property (@(posedge clock) disable iff (rst)
      (flags[3] && flags[4] && !st_reg.nmi_pending && best_level == st_reg.prio_a[3:0]
       && st_reg.prio_a[3:0] == st_reg.prio_b[7:4]) |-> best_source != 5'h04)
      else $error("tie resolved to later pin");

   chk_sync_edge: assert property (@(posedge clock) disable iff (rst)
      pin_fall[0] |-> (pin_low[0] && !$past(pin_low[0])))
      else $error("edge not between synchronised samples");

   chk_accept_drops: assert property (@(posedge clock) disable iff (rst)
      (cpu_accept && st_reg.irq) |=> !st_reg.irq)
      else $error("request held after acceptance");
endmodule

// ==== verification/eic_cpu_model.sv ====
// CPU core model: takes forwarded requests and runs exception entry
module eic_cpu_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       cpu_irq,
   input  wire logic [3:0] irq_level,
   input  wire logic [4:0] irq_source,
   input  wire logic       enable,
   input  wire logic [3:0] wait_cycles,
   input  wire logic       load_mask,
   input  wire logic [3:0] mask_value,
   output logic      [3:0] cpu_mask_level,
   output logic            cpu_accept,
   output logic      [4:0] taken_source,
   output logic      [7:0] n_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  decode_cnt;
   logic [7:0]  stack_depth;
   logic [31:0] pc;
   always_ff @(posedge clock) begin
      if (rst) begin
         cpu_mask_level <= 4'hf;
         cpu_accept <= 1'b0;
         decode_cnt <= 4'h0;
         stack_depth <= 8'h0;
         pc <= 32'h0;
         taken_source <= 5'h1f;
         n_taken <= 8'h0;
      end else if (cpu_accept) begin
         // One pulse only; the controller drops the request next cycle
         cpu_accept <= 1'b0;
         decode_cnt <= 4'h0;
      end else if (load_mask) begin
         cpu_mask_level <= mask_value;
      end else if (enable && cpu_irq) begin
         // Slow decode stretches the wait before entry
         if (decode_cnt == wait_cycles) begin
            cpu_accept <= 1'b1;
            stack_depth <= stack_depth + 8'h2;
            cpu_mask_level <= irq_level;
            pc <= {25'h0, irq_source, 2'b00};
            taken_source <= irq_source;
            n_taken <= n_taken + 8'h1;
         end else begin
            decode_cnt <= decode_cnt + 4'h1;
         end
      end
   end
endmodule

// ==== verification/tb_eic_ctrl.sv ====
// Testbench: registers, pin detection, arbitration and CPU hand-off
module tb_eic_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import eic_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        nmi_pin = 1'b1;
   logic [5:0]  ext_req_n = 6'h3f;
   logic        enable = 1'b1;
   logic [3:0]  wait_cycles = 4'h0;
   logic        load_mask = 1'b0;
   logic [3:0]  mask_value = 4'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [3:0]  cpu_mask_level;
   logic        cpu_accept;
   logic        cpu_irq;
   logic [3:0]  irq_level;
   logic [4:0]  irq_source;
   logic [4:0]  taken_source;
   logic [7:0]  n_taken;
   int          fails = 0;
   int          n_tests = 0;
   logic [31:0] d;

   eic_ctrl i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nmi_pin(nmi_pin),
      .ext_req_n(ext_req_n), .cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept),
      .cpu_irq(cpu_irq), .irq_level(irq_level), .irq_source(irq_source));
   eic_cpu_model i_cpu (.clock(clock), .rst(rst), .cpu_irq(cpu_irq), .irq_level(irq_level),
      .irq_source(irq_source), .enable(enable), .wait_cycles(wait_cycles),
      .load_mask(load_mask), .mask_value(mask_value), .cpu_mask_level(cpu_mask_level),
      .cpu_accept(cpu_accept), .taken_source(taken_source), .n_taken(n_taken));

   always #5 clock = ~clock;

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report;
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         fails++;
         final_report();
      end
   endtask

   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      check($sformatf("reg %h", a), r, exp);
      check("bus response", 32'(hresp), 32'h0);
   endtask

   task automatic pulse(input logic [5:0] m);
      ext_req_n <= ~m;
      repeat (3) @(posedge clock);
      ext_req_n <= 6'h3f;
      repeat (6) @(posedge clock);
   endtask

   task automatic set_mask(input logic [3:0] v);
      mask_value <= v;
      load_mask <= 1'b1;
      @(posedge clock);
      load_mask <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task automatic wait_taken(input logic [7:0] n);
      int k;
      k = 0;
      while (n_taken !== n && k < 60) begin
         @(posedge clock);
         k++;
      end
      check("accepted count", 32'(n_taken), 32'(n));
   endtask

   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rchk(ADDR_CONTROL, 32'h8000);
      rchk(ADDR_STATUS, 32'h0);
      rchk(ADDR_PRIO_A, 32'h0);
      rchk(12'h01c, 32'h0);
      bus(ADDR_CONTROL, 1'b1, 32'h0000_01f3, d);
      rchk(ADDR_CONTROL, 32'h81f3);
      set_mask(4'h0);
      nmi_pin <= 1'b0;
      repeat (8) @(posedge clock);
      rchk(ADDR_CONTROL, 32'h01f3);
      check("nmi fall ignored", 32'(n_taken), 32'h0);
      nmi_pin <= 1'b1;
      wait_taken(8'd1);
      check("nmi source", 32'(taken_source), 32'(NMI_SOURCE));
      bus(ADDR_CONTROL, 1'b1, 32'h00f3, d);
      set_mask(4'h0);
      nmi_pin <= 1'b0;
      wait_taken(8'd2);
      set_mask(4'h0);
      nmi_pin <= 1'b1;
      repeat (10) @(posedge clock);
      check("nmi rise ignored", 32'(n_taken), 32'h2);
      set_mask(4'hf);
      pulse(6'h02);
      bus(ADDR_STATUS, 1'b1, 32'h0, d);
      rchk(ADDR_STATUS, 32'h40);
      bus(ADDR_STATUS, 1'b1, 32'h0, d);
      rchk(ADDR_STATUS, 32'h0);
      bus(ADDR_CONTROL, 1'b1, 32'h0, d);
      ext_req_n <= 6'h3e;
      repeat (6) @(posedge clock);
      bus(ADDR_STATUS, 1'b1, 32'h0, d);
      rchk(ADDR_STATUS, 32'h80);
      ext_req_n <= 6'h3f;
      repeat (6) @(posedge clock);
      rchk(ADDR_STATUS, 32'h0);
      bus(ADDR_CONTROL, 1'b1, 32'h00f3, d);
      bus(ADDR_PRIO_A, 1'b1, 32'h1234, d);
      bus(ADDR_PRIO_B, 1'b1, 32'h0045, d);
      rchk(ADDR_PRIO_B, 32'h45);
      enable <= 1'b0;
      wait_cycles <= 4'h5;
      set_mask(4'h3);
      pulse(6'h19);
      check("irq source", 32'(irq_source), 32'h3);
      check("irq level", 32'(irq_level), 32'h4);
      check("forwarded", 32'(cpu_irq), 32'h1);
      rchk(ADDR_ACCEPT, 32'h283);
      rchk(ADDR_CPU_MASK, 32'h3);
      set_mask(4'h4);
      check("equal to mask", 32'(cpu_irq), 32'h0);
      set_mask(4'h3);
      enable <= 1'b1;
      wait_taken(8'd3);
      check("taken pin", 32'(taken_source), 32'h3);
      repeat (4) @(posedge clock);
      check("after entry", 32'(cpu_irq), 32'h0);
      check("next source", 32'(irq_source), 32'h4);
      rchk(ADDR_STATUS, 32'h82);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rchk(ADDR_STATUS, 32'h0);
      rchk(ADDR_CONTROL, 32'h8000);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      final_report();
   end
endmodule
